// *** rtl/rpb_bridge.sv ***
// Remote pipe transfer bridge core
`timescale 1ns/10ps
`include "rpb_defines.svh"
// Notes on behaviour
// - Fixed count of remote pipes, at least one.
// - Two remote pipes per supported downstream port.
// - Request packet length must match its request type.
// - Addressed pipe must be configured for the request's transfer type.
// - Malformed request never halts bulk OUT; it and its data are accepted. Here a malformed request waits unacked while an error result is pending.
// - Malformed request yields notification and a request error result.
// - Every finished transfer posts a transfer-complete notification.
// - Bulk IN returns result whose count states following data.
// - Failed transfer returns result only, no data.
// - Requests above pipe concurrency are NAKed until one completes.
// - Downstream port status changes are reported to the host.
// - Port count field advertised, never above 127.
// - Asynchronous downstream device events are forwarded to the host.
// - Full and high speed upstream; isochronous refused at full speed.
// - At least four endpoints exposed.
// - Descriptors rewritable; descriptor read reports current pipe state.
// - Notification only says data waits; it carries no status.
// - OUT data portions go downstream in arrival order.
module rpb_bridge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Bulk OUT endpoint
  input wire logic out_valid_i,
  input wire rpb_pkg::rpb_out_pkt_s out_pkt_i,
  output logic out_ack_o,
  output logic out_nak_o,
  // Default control pipe descriptor access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [`RPB_PIPE_W-1:0] cfg_pipe_i,
  input wire rpb_pkg::rpb_desc_s cfg_desc_i,
  output logic cfg_ack_o,
  output logic cfg_stall_o,
  output rpb_pkg::rpb_pipe_rd_s cfg_rdata_o,
  // Downstream host controller
  output logic dn_req_valid_o,
  output rpb_pkg::rpb_dn_req_s dn_req_o,
  output logic dn_data_valid_o,
  output logic [`RPB_LEN_W-1:0] dn_data_len_o,
  input wire logic dn_done_i,
  input wire logic [`RPB_PIPE_W-1:0] dn_done_pipe_i,
  input wire logic dn_done_ok_i,
  input wire logic [`RPB_TAG_W-1:0] dn_done_tag_i,
  input wire logic [`RPB_LEN_W-1:0] dn_done_len_i,
  output logic dn_done_ready_o,
  // Bulk IN result
  output logic rslt_valid_o,
  output rpb_pkg::rpb_result_s rslt_o,
  input wire logic rslt_taken_i,
  // Interrupt notification endpoint
  output logic notif_valid_o,
  output rpb_pkg::rpb_notif_s notif_o,
  // Ports, device events and speed
  input wire logic [`RPB_NUM_PORTS-1:0] port_status_i,
  input wire logic dev_evt_i,
  input wire logic [`RPB_TAG_W-1:0] dev_evt_code_i,
  input wire logic high_speed_i,
  output logic [7:0] port_count_field_o,
  output logic [2:0] endpoint_count_o
);
  rpb_pkg::rpb_state_e state;
  rpb_pkg::rpb_desc_s desc [`RPB_NUM_PIPES];
  logic [`RPB_CNT_W-1:0] pend [`RPB_NUM_PIPES];
  logic [`RPB_LEN_W-1:0] data_left;
  logic bad_req;
  logic [`RPB_TAG_W-1:0] err_tag;
  logic err_pend;
  logic [`RPB_NUM_PORTS-1:0] ps1, ps2, ps3, port_filt;
  logic hs1, hs2, hs3, hs_filt;
  logic port_chg_pend, dev_evt_pend;
  logic [`RPB_TAG_W-1:0] dev_code;
  logic take;
  logic req_ok, req_busy, acc_req;
  logic rslt_post;
  rpb_pkg::rpb_desc_s pd;

  // Pipe holds at least one pending transfer
  function automatic logic pipe_busy(input logic [`RPB_CNT_W-1:0] cnt);
    pipe_busy = (cnt != `RPB_ZERO_CNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Constant descriptor fields
  always_ff @(posedge clk_i) begin
    port_count_field_o <= 8'(`RPB_NUM_PORTS);
    endpoint_count_o <= 3'(`RPB_NUM_EPS);
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change accepted when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {ps1, ps2, ps3, port_filt} <= '0;
      {hs1, hs2, hs3, hs_filt} <= 4'h0;
    end else begin
      ps1 <= port_status_i;
      ps2 <= ps1;
      ps3 <= ps2;
      hs1 <= high_speed_i;
      hs2 <= hs1;
      hs3 <= hs2;
      if (ps2 == ps3) port_filt <= ps3;
      if (hs2 == hs3) hs_filt <= hs3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request checks on the offered packet
  assign pd = desc[out_pkt_i.pipe];
  assign take = out_valid_i && !out_ack_o && !out_nak_o;
  always_comb begin
    req_ok = 1'b1;
    if (out_pkt_i.rtype == rpb_pkg::RPB_RQ_ABORT) begin
      if (out_pkt_i.len != `RPB_LEN_ABORT) req_ok = 1'b0;
    end else begin
      if (out_pkt_i.len != `RPB_LEN_XFER) req_ok = 1'b0;
      if (!pd.configured || pd.xtype != out_pkt_i.rtype) req_ok = 1'b0;
      if (out_pkt_i.rtype == rpb_pkg::RPB_RQ_ISOC && !hs_filt) begin
        req_ok = 1'b0;
      end
    end
  end
  // Good transfer requests beyond concurrency are held off
  assign req_busy = req_ok && out_pkt_i.rtype != rpb_pkg::RPB_RQ_ABORT &&
    pend[out_pkt_i.pipe] >= pd.max_conc;
  // Error path needs the single error slot free
  assign acc_req = take && !out_pkt_i.is_data && state != rpb_pkg::RPB_S_ERR &&
    !req_busy && (req_ok || !err_pend);

  ////////////////////////////////////////////////////////////////////////
  // Bulk OUT sequencing: request, then data portions
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= rpb_pkg::RPB_S_IDLE;
      data_left <= `RPB_ZERO_LEN;
      bad_req <= 1'b0;
      out_ack_o <= 1'b0;
      out_nak_o <= 1'b0;
      err_tag <= '0;
    end else begin
      out_ack_o <= 1'b0;
      out_nak_o <= 1'b0;
      if (take && out_pkt_i.is_data) begin
        out_ack_o <= 1'b1;
        if (out_pkt_i.len >= data_left) begin
          data_left <= `RPB_ZERO_LEN;
          state <= bad_req ? rpb_pkg::RPB_S_ERR : rpb_pkg::RPB_S_IDLE;
        end else begin
          data_left <= data_left - out_pkt_i.len;
        end
      end else if (state == rpb_pkg::RPB_S_ERR) begin
        state <= rpb_pkg::RPB_S_IDLE; // error result pending from this cycle, posted next
        bad_req <= 1'b0;
      end else if (acc_req) begin
        out_ack_o <= 1'b1;
        bad_req <= !req_ok;
        err_tag <= out_pkt_i.tag;
        if (out_pkt_i.dir_out && out_pkt_i.dlen != `RPB_ZERO_LEN &&
            out_pkt_i.rtype != rpb_pkg::RPB_RQ_ABORT) begin
          state <= rpb_pkg::RPB_S_DATA;
          data_left <= out_pkt_i.dlen;
        end else begin
          state <= req_ok ? rpb_pkg::RPB_S_IDLE : rpb_pkg::RPB_S_ERR;
        end
      end else if (take && !out_pkt_i.is_data && req_busy) begin
        out_nak_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Downstream request and in-order data forwarding
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dn_req_valid_o <= 1'b0;
      dn_req_o <= '0;
      dn_data_valid_o <= 1'b0;
      dn_data_len_o <= `RPB_ZERO_LEN;
    end else begin
      dn_req_valid_o <= acc_req && req_ok;
      dn_data_valid_o <= take && out_pkt_i.is_data && !bad_req &&
        state == rpb_pkg::RPB_S_DATA;
      dn_data_len_o <= out_pkt_i.len;
      if (acc_req && req_ok) begin
        dn_req_o.abort <= out_pkt_i.rtype == rpb_pkg::RPB_RQ_ABORT;
        dn_req_o.pipe <= out_pkt_i.pipe;
        dn_req_o.xtype <= out_pkt_i.rtype;
        dn_req_o.dir_out <= out_pkt_i.dir_out;
        dn_req_o.dlen <= out_pkt_i.dlen;
        dn_req_o.tag <= out_pkt_i.tag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pipe descriptor and pending transfer count
  for (genvar g = 0; g < `RPB_NUM_PIPES; g++) begin : g_pipe
    logic inc, dec;
    assign inc = acc_req && req_ok && out_pkt_i.pipe == g &&
      out_pkt_i.rtype != rpb_pkg::RPB_RQ_ABORT;
    assign dec = dn_done_i && dn_done_ready_o && dn_done_pipe_i == g &&
      pipe_busy(pend[g]);
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        pend[g] <= `RPB_ZERO_CNT;
      end else if (inc && !dec) begin
        pend[g] <= pend[g] + `RPB_ONE_CNT;
      end else if (dec && !inc) begin
        pend[g] <= pend[g] - `RPB_ONE_CNT;
      end
    end
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        desc[g] <= '0;
      end else if (cfg_wr_i && cfg_pipe_i == g && !pipe_busy(pend[g])) begin
        desc[g] <= cfg_desc_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control pipe answers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_stall_o <= 1'b0;
      cfg_rdata_o <= '0;
    end else begin
      cfg_ack_o <= cfg_rd_i || (cfg_wr_i && !pipe_busy(pend[cfg_pipe_i]));
      cfg_stall_o <= cfg_wr_i && pipe_busy(pend[cfg_pipe_i]);
      if (cfg_rd_i) begin
        cfg_rdata_o.desc <= desc[cfg_pipe_i];
        cfg_rdata_o.idle <= !pipe_busy(pend[cfg_pipe_i]);
        cfg_rdata_o.pending <= pend[cfg_pipe_i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result slot: request errors first, then downstream completions
  assign rslt_post = !rslt_valid_o || rslt_taken_i;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_pend <= 1'b0;
      dn_done_ready_o <= 1'b0;
      rslt_valid_o <= 1'b0;
      rslt_o <= '0;
    end else begin
      dn_done_ready_o <= 1'b0;
      if (rslt_taken_i) rslt_valid_o <= 1'b0;
      if (rslt_post && err_pend) begin
        err_pend <= 1'b0;
        rslt_valid_o <= 1'b1;
        rslt_o.tag <= err_tag;
        rslt_o.status <= rpb_pkg::RPB_ST_REQ_ERR;
        rslt_o.in_len <= `RPB_ZERO_LEN;
      end else if (dn_done_i && dn_done_ready_o) begin
        rslt_valid_o <= 1'b1;
        rslt_o.tag <= dn_done_tag_i;
        rslt_o.status <= dn_done_ok_i ? rpb_pkg::RPB_ST_OK :
          rpb_pkg::RPB_ST_FAIL;
        rslt_o.in_len <= dn_done_ok_i ? dn_done_len_i :
          `RPB_ZERO_LEN;
      end else begin
        dn_done_ready_o <= dn_done_i && rslt_post && !err_pend &&
          state != rpb_pkg::RPB_S_ERR && !dn_done_ready_o;
      end
      // New request error wins over the clear above
      if (state == rpb_pkg::RPB_S_ERR) err_pend <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Notifications: transfer done beats port change beats device event
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_chg_pend <= 1'b0;
      dev_evt_pend <= 1'b0;
      dev_code <= '0;
      notif_valid_o <= 1'b0;
      notif_o <= '0;
    end else begin
      notif_valid_o <= 1'b0;
      if ((rslt_post && err_pend) || (dn_done_i && dn_done_ready_o)) begin
        notif_valid_o <= 1'b1;
        notif_o.kind <= rpb_pkg::RPB_NT_XFER;
        notif_o.pipe <= dn_done_pipe_i;
        notif_o.code <= '0;
      end else if (port_chg_pend) begin
        notif_valid_o <= 1'b1;
        notif_o.kind <= rpb_pkg::RPB_NT_PORT;
        notif_o.pipe <= '0;
        notif_o.code <= 8'(port_filt);
        port_chg_pend <= 1'b0;
      end else if (dev_evt_pend) begin
        notif_valid_o <= 1'b1;
        notif_o.kind <= rpb_pkg::RPB_NT_DEV;
        notif_o.pipe <= '0;
        notif_o.code <= dev_code;
        dev_evt_pend <= 1'b0;
      end
      // New events win over the clear above
      if ((ps2 == ps3) && (ps3 != port_filt)) port_chg_pend <= 1'b1;
      if (dev_evt_i) begin
        dev_evt_pend <= 1'b1;
        dev_code <= dev_evt_code_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_bad_req;
    acc_req && !req_ok;
  endsequence
  sequence s_err_result;
    rslt_valid_o && rslt_o.status == rpb_pkg::RPB_ST_REQ_ERR;
  endsequence
  chk_bad_req_acked: assert property (s_bad_req |=> out_ack_o)
    else $error("malformed request not accepted");
  chk_bad_req_result: assert property (
    s_bad_req and (!out_pkt_i.dir_out && !rslt_valid_o)
    |-> ##[1:4] s_err_result)
    else $error("request error result missing");
  chk_len_check: assert property (take && !out_pkt_i.is_data &&
    out_pkt_i.rtype == rpb_pkg::RPB_RQ_BULK &&
    out_pkt_i.len != `RPB_LEN_XFER |=> !dn_req_valid_o)
    else $error("bad length forwarded");
  chk_type_match: assert property (dn_req_valid_o && !dn_req_o.abort |->
    desc[dn_req_o.pipe].xtype == dn_req_o.xtype)
    else $error("pipe type mismatch forwarded");
  chk_nak_busy: assert property (take && !out_pkt_i.is_data &&
    req_busy && state != rpb_pkg::RPB_S_ERR |=> out_nak_o && !out_ack_o)
    else $error("over-concurrency request not refused");
  chk_fail_no_data: assert property (rslt_valid_o &&
    rslt_o.status != rpb_pkg::RPB_ST_OK |-> rslt_o.in_len == '0)
    else $error("failed result carries data");
  chk_done_notif: assert property (dn_done_i && dn_done_ready_o |=>
    notif_valid_o && notif_o.kind == rpb_pkg::RPB_NT_XFER && rslt_valid_o)
    else $error("completion not notified");
  chk_busy_wr_keep: assert property (
    cfg_wr_i && pipe_busy(pend[cfg_pipe_i])
    |=> cfg_stall_o && desc[$past(cfg_pipe_i)] == $past(desc[cfg_pipe_i]))
    else $error("busy pipe descriptor changed");
  chk_isoc_full: assert property (take && !hs_filt &&
    out_pkt_i.rtype == rpb_pkg::RPB_RQ_ISOC |=> !dn_req_valid_o)
    else $error("isochronous passed at full speed");
  chk_port_report: assert property ($rose(port_chg_pend) |->
    ##[1:3] notif_valid_o && notif_o.kind == rpb_pkg::RPB_NT_PORT)
    else $error("port change not reported");
endmodule

// *** rtl/rpb_defines.svh ***
// Constants for the remote pipe transfer bridge
`ifndef RPB_DEFINES_SVH
`define RPB_DEFINES_SVH
`define RPB_NUM_PORTS 2
`define RPB_NUM_PIPES 4
`define RPB_PIPE_W 2
`define RPB_NUM_EPS 4
`define RPB_MAX_PORTS 127
`define RPB_CNT_W 3
`define RPB_LEN_W 16
`define RPB_TAG_W 8
`define RPB_LEN_XFER 16'h0010
`define RPB_LEN_ABORT 16'h0008
`define RPB_ZERO_LEN 16'h0000
`define RPB_ZERO_CNT 3'h0
`define RPB_ONE_CNT 3'h1
`endif

// *** rtl/rpb_pkg.sv ***
// Types for the remote pipe transfer bridge
`include "rpb_defines.svh"
package rpb_pkg;
  // Request kinds on the bulk OUT endpoint
  typedef enum logic [1:0] {
    RPB_RQ_CTL = 2'b00,
    RPB_RQ_BULK = 2'b01,
    RPB_RQ_ISOC = 2'b10,
    RPB_RQ_ABORT = 2'b11
  } rpb_rtype_e;
  // Result status codes
  typedef enum logic [1:0] {
    RPB_ST_OK = 2'b00,
    RPB_ST_FAIL = 2'b01,
    RPB_ST_REQ_ERR = 2'b10
  } rpb_status_e;
  // Notification kinds
  typedef enum logic [1:0] {
    RPB_NT_XFER = 2'b00,
    RPB_NT_PORT = 2'b01,
    RPB_NT_DEV = 2'b10
  } rpb_nkind_e;
  // One packet offered on the bulk OUT endpoint
  typedef struct packed {
    logic is_data;
    logic [`RPB_LEN_W-1:0] len;
    rpb_rtype_e rtype;
    logic [`RPB_PIPE_W-1:0] pipe;
    logic dir_out;
    logic [`RPB_LEN_W-1:0] dlen;
    logic [`RPB_TAG_W-1:0] tag;
  } rpb_out_pkt_s;
  // Remote pipe descriptor
  typedef struct packed {
    logic configured;
    rpb_rtype_e xtype;
    logic dir_out;
    logic [`RPB_CNT_W-1:0] max_conc;
  } rpb_desc_s;
  // Request to the downstream host controller
  typedef struct packed {
    logic abort;
    logic [`RPB_PIPE_W-1:0] pipe;
    rpb_rtype_e xtype;
    logic dir_out;
    logic [`RPB_LEN_W-1:0] dlen;
    logic [`RPB_TAG_W-1:0] tag;
  } rpb_dn_req_s;
  // Transfer result on the bulk IN endpoint
  typedef struct packed {
    logic [`RPB_TAG_W-1:0] tag;
    rpb_status_e status;
    logic [`RPB_LEN_W-1:0] in_len;
  } rpb_result_s;
  // Notification record, never the status itself
  typedef struct packed {
    rpb_nkind_e kind;
    logic [`RPB_PIPE_W-1:0] pipe;
    logic [`RPB_TAG_W-1:0] code;
  } rpb_notif_s;
  // Descriptor read answer
  typedef struct packed {
    rpb_desc_s desc;
    logic idle;
    logic [`RPB_CNT_W-1:0] pending;
  } rpb_pipe_rd_s;
  typedef enum logic [1:0] {
    RPB_S_IDLE = 2'b00,
    RPB_S_DATA = 2'b01,
    RPB_S_ERR = 2'b10
  } rpb_state_e;
endpackage

// *** tb/rpb_dn_model.sv ***
// Downstream host controller model for the bridge bench
`timescale 1ns/10ps
`include "rpb_defines.svh"
module rpb_dn_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Bench controls
  input wire logic hold_i,
  input wire logic fail_i,
  // Bridge side
  input wire logic dn_req_valid_i,
  input wire rpb_pkg::rpb_dn_req_s dn_req_i,
  input wire logic dn_done_ready_i,
  output logic dn_done_o,
  output logic [`RPB_PIPE_W-1:0] dn_done_pipe_o,
  output logic dn_done_ok_o,
  output logic [`RPB_TAG_W-1:0] dn_done_tag_o,
  output logic [`RPB_LEN_W-1:0] dn_done_len_o
);
  rpb_pkg::rpb_dn_req_s pend_q[$];
  rpb_pkg::rpb_dn_req_s cur;
  logic ok;
  logic [7:0] churn = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // Queue forwarded non-abort requests, offer one completion, hold until taken
  always @(posedge clk_i) begin
    churn <= churn + 8'h01;
    if (srst_i) begin
      pend_q.delete();
      dn_done_o <= 1'b0;
    end else begin
      if (dn_req_valid_i && !dn_req_i.abort) begin
        pend_q.push_back(dn_req_i);
      end
      if (dn_done_o && dn_done_ready_i) begin
        dn_done_o <= 1'b0;
        void'(pend_q.pop_front());
      end else if (!dn_done_o && !hold_i && pend_q.size() != 0) begin
        dn_done_o <= 1'b1;
        cur <= pend_q[0];
        ok <= !fail_i;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Info lines churn while no completion is offered
  assign dn_done_pipe_o = dn_done_o ? cur.pipe : churn[1:0];
  assign dn_done_tag_o = dn_done_o ? cur.tag : churn;
  assign dn_done_ok_o = dn_done_o ? ok : churn[0];
  assign dn_done_len_o = dn_done_o ? (cur.dir_out ? 16'h0000 : cur.dlen)
                                   : {churn, ~churn};
endmodule

// *** tb/test_remote_pipe_transfer_bridge.sv ***
// Self-checking bench for the remote pipe transfer bridge
`timescale 1ns/10ps
`include "rpb_defines.svh"
module test_remote_pipe_transfer_bridge;
  localparam rpb_pkg::rpb_rtype_e CTL = rpb_pkg::RPB_RQ_CTL;
  localparam rpb_pkg::rpb_rtype_e BULK = rpb_pkg::RPB_RQ_BULK;
  localparam rpb_pkg::rpb_rtype_e ISOC = rpb_pkg::RPB_RQ_ISOC;
  localparam rpb_pkg::rpb_rtype_e ABRT = rpb_pkg::RPB_RQ_ABORT;
  localparam rpb_pkg::rpb_status_e OK = rpb_pkg::RPB_ST_OK;
  localparam rpb_pkg::rpb_status_e BAD = rpb_pkg::RPB_ST_FAIL;
  localparam rpb_pkg::rpb_status_e RQERR = rpb_pkg::RPB_ST_REQ_ERR;
  logic clk_i, srst_i, out_valid_i, out_ack_o, out_nak_o;
  rpb_pkg::rpb_out_pkt_s out_pkt_i;
  logic cfg_wr_i, cfg_rd_i, cfg_ack_o, cfg_stall_o;
  logic [`RPB_PIPE_W-1:0] cfg_pipe_i, dn_done_pipe_i;
  rpb_pkg::rpb_desc_s cfg_desc_i, d0;
  rpb_pkg::rpb_pipe_rd_s cfg_rdata_o;
  logic dn_req_valid_o, dn_data_valid_o, dn_done_i, dn_done_ok_i;
  logic dn_done_ready_o, rslt_valid_o, rslt_taken_i, notif_valid_o;
  rpb_pkg::rpb_dn_req_s dn_req_o, last_req;
  logic [`RPB_LEN_W-1:0] dn_data_len_o, dn_done_len_i, last_len;
  logic [`RPB_TAG_W-1:0] dn_done_tag_i, dev_evt_code_i;
  rpb_pkg::rpb_result_s rslt_o;
  rpb_pkg::rpb_notif_s notif_o, last_notif;
  logic [`RPB_NUM_PORTS-1:0] port_status_i;
  logic dev_evt_i, high_speed_i, hold, fail;
  logic [7:0] port_count_field_o;
  logic [2:0] endpoint_count_o;
  int fail_count = 0;
  int check_count = 0;
  int n_req = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  rpb_bridge dut (.clk_i(clk_i), .srst_i(srst_i),
    .out_valid_i(out_valid_i), .out_pkt_i(out_pkt_i),
    .out_ack_o(out_ack_o), .out_nak_o(out_nak_o), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_pipe_i(cfg_pipe_i), .cfg_desc_i(cfg_desc_i),
    .cfg_ack_o(cfg_ack_o), .cfg_stall_o(cfg_stall_o),
    .cfg_rdata_o(cfg_rdata_o), .dn_req_valid_o(dn_req_valid_o),
    .dn_req_o(dn_req_o), .dn_data_valid_o(dn_data_valid_o),
    .dn_data_len_o(dn_data_len_o), .dn_done_i(dn_done_i),
    .dn_done_pipe_i(dn_done_pipe_i), .dn_done_ok_i(dn_done_ok_i),
    .dn_done_tag_i(dn_done_tag_i), .dn_done_len_i(dn_done_len_i),
    .dn_done_ready_o(dn_done_ready_o), .rslt_valid_o(rslt_valid_o),
    .rslt_o(rslt_o), .rslt_taken_i(rslt_taken_i),
    .notif_valid_o(notif_valid_o), .notif_o(notif_o),
    .port_status_i(port_status_i), .dev_evt_i(dev_evt_i),
    .dev_evt_code_i(dev_evt_code_i), .high_speed_i(high_speed_i),
    .port_count_field_o(port_count_field_o),
    .endpoint_count_o(endpoint_count_o));
  rpb_dn_model partner (.clk_i(clk_i), .srst_i(srst_i), .hold_i(hold),
    .fail_i(fail), .dn_req_valid_i(dn_req_valid_o), .dn_req_i(dn_req_o),
    .dn_done_ready_i(dn_done_ready_o), .dn_done_o(dn_done_i),
    .dn_done_pipe_o(dn_done_pipe_i), .dn_done_ok_o(dn_done_ok_i),
    .dn_done_tag_o(dn_done_tag_i), .dn_done_len_o(dn_done_len_i));
  ////////////////////////////////////////////////////////////////////////
  // Capture one-cycle pulses from the bridge
  always @(posedge clk_i) begin
    if (dn_req_valid_o) begin
      last_req <= dn_req_o;
      n_req <= n_req + 1;
    end
    if (dn_data_valid_o) begin
      last_len <= dn_data_len_o;
    end
    if (notif_valid_o) begin
      last_notif <= notif_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic rpb_pkg::rpb_out_pkt_s mk(input logic d,
      input logic [15:0] len, input rpb_pkg::rpb_rtype_e t,
      input logic [1:0] p, input logic dir, input logic [15:0] dl,
      input logic [7:0] tag);
    mk = '{d, len, t, p, dir, dl, tag};
  endfunction
  // Offer a packet, expect ack (1) or nak (2)
  task automatic send(input rpb_pkg::rpb_out_pkt_s p, input logic [1:0] ex,
                      input string what);
    int n;
    n = 0;
    @(negedge clk_i);
    out_pkt_i = p;
    out_valid_i = 1'b1;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (out_ack_o !== 1'b1 && out_nak_o !== 1'b1 && n < 20);
    chk(what, {30'h0, ex}, {30'h0, out_nak_o, out_ack_o});
    @(negedge clk_i);
    out_valid_i = 1'b0;
  endtask
  // Descriptor write or read, expect ack (1) or stall (2)
  task automatic cfg(input logic wr, input logic [1:0] p,
      input rpb_pkg::rpb_desc_s d, input logic [1:0] ex, input string what);
    @(negedge clk_i);
    cfg_wr_i = wr;
    cfg_rd_i = !wr;
    cfg_pipe_i = p;
    cfg_desc_i = d;
    @(posedge clk_i);
    #1;
    chk(what, {30'h0, ex}, {30'h0, cfg_stall_o, cfg_ack_o});
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
  endtask
  // Wait for a result, judge it and its notification, then consume it
  task automatic result(input logic [7:0] tag, input rpb_pkg::rpb_status_e st,
      input logic [15:0] len, input logic use_tag, input string what);
    int n;
    n = 0;
    while (rslt_valid_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({what, " valid"}, 1, rslt_valid_o);
    chk({what, " status"}, st, rslt_o.status);
    chk({what, " length"}, len, rslt_o.in_len);
    if (use_tag) chk({what, " tag"}, tag, rslt_o.tag);
    @(posedge clk_i);
    #1;
    chk({what, " notif"}, rpb_pkg::RPB_NT_XFER, last_notif.kind);
    @(negedge clk_i);
    rslt_taken_i = 1'b1;
    @(negedge clk_i);
    rslt_taken_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_config;
    d0 = '{1'b1, BULK, 1'b1, 3'h1};
    chk("port count", `RPB_NUM_PORTS, port_count_field_o);
    chk("endpoints", `RPB_NUM_EPS, endpoint_count_o);
    cfg(1'b1, 2'h0, d0, 2'h1, "write pipe0");
    cfg(1'b1, 2'h1, '{1'b1, BULK, 1'b0, 3'h2}, 2'h1, "write pipe1");
    cfg(1'b1, 2'h2, '{1'b1, ISOC, 1'b0, 3'h1}, 2'h1, "write pipe2");
    cfg(1'b0, 2'h0, d0, 2'h1, "read pipe0");
    chk("read desc", d0, cfg_rdata_o.desc);
    chk("read idle", 1, cfg_rdata_o.idle);
  endtask
  task automatic t_out;
    @(negedge clk_i);
    hold = 1'b1;
    send(mk(0, `RPB_LEN_XFER, BULK, 0, 1, 16'h000c, 8'h11), 1, "out rq");
    send(mk(1, 16'h0008, BULK, 0, 1, 0, 0), 1, "data a");
    repeat (2) @(posedge clk_i);
    chk("fwd tag", 8'h11, last_req.tag);
    chk("fwd len a", 16'h0008, last_len);
    send(mk(1, 16'h0004, BULK, 0, 1, 0, 0), 1, "data b");
    repeat (2) @(posedge clk_i);
    chk("fwd len b", 16'h0004, last_len);
    send(mk(0, `RPB_LEN_XFER, BULK, 0, 1, 16'h0004, 8'h12), 2, "limit");
    cfg(1'b1, 2'h0, '{1'b1, CTL, 1'b0, 3'h3}, 2'h2, "busy wr");
    cfg(1'b0, 2'h0, d0, 2'h1, "busy rd");
    chk("kept desc", d0, cfg_rdata_o.desc);
    chk("pending", 1, cfg_rdata_o.pending);
    @(negedge clk_i);
    hold = 1'b0;
    result(8'h11, OK, 16'h0000, 1'b1, "out result");
    send(mk(0, `RPB_LEN_ABORT, ABRT, 0, 0, 0, 8'h11), 1, "abort");
    repeat (2) @(posedge clk_i);
    chk("abort fwd", 1, last_req.abort);
    cfg(1'b0, 2'h0, d0, 2'h1, "save pipe0");
    chk("save idle", 1, cfg_rdata_o.idle);
    cfg(1'b1, 2'h0, '{1'b1, CTL, 1'b0, 3'h1}, 2'h1, "retarget");
    cfg(1'b0, 2'h0, d0, 2'h1, "reread pipe0");
    chk("retarget type", CTL, cfg_rdata_o.desc.xtype);
  endtask
  task automatic t_err;
    send(mk(0, 16'h0012, BULK, 1, 1, 16'h0004, 8'h30), 1, "bad len");
    send(mk(1, 16'h0004, BULK, 1, 1, 0, 0), 1, "data after");
    result(8'h30, RQERR, 16'h0000, 1'b1, "bad len");
    send(mk(0, `RPB_LEN_XFER, CTL, 1, 0, 16'h0004, 8'h31), 1, "bad type");
    result(8'h31, RQERR, 16'h0000, 1'b1, "bad type");
  endtask
  task automatic t_in;
    send(mk(0, `RPB_LEN_XFER, BULK, 1, 0, 16'h0020, 8'h21), 1, "in rq");
    result(8'h21, OK, 16'h0020, 1'b1, "in ok");
    @(negedge clk_i);
    fail = 1'b1;
    send(mk(0, `RPB_LEN_XFER, BULK, 1, 0, 16'h0020, 8'h22), 1, "in rq2");
    result(8'h22, BAD, 16'h0000, 1'b1, "in fail");
    fail = 1'b0;
  endtask
  task automatic t_speed;
    int r0;
    send(mk(0, `RPB_LEN_XFER, ISOC, 2, 0, 16'h0008, 8'h41), 1, "iso fs");
    result(8'h41, RQERR, 16'h0000, 1'b1, "iso fs");
    high_speed_i = 1'b1;
    repeat (8) @(posedge clk_i);
    r0 = n_req;
    send(mk(0, `RPB_LEN_XFER, ISOC, 2, 0, 16'h0008, 8'h42), 1, "iso hs");
    repeat (2) @(posedge clk_i);
    chk("iso fwd", r0 + 1, n_req);
    result(8'h42, OK, 16'h0008, 1'b1, "iso hs");
  endtask
  task automatic t_events;
    @(negedge clk_i);
    port_status_i = 2'b10;
    repeat (12) @(posedge clk_i);
    chk("port kind", rpb_pkg::RPB_NT_PORT, last_notif.kind);
    chk("port code", 8'h02, last_notif.code);
    @(negedge clk_i);
    dev_evt_i = 1'b1;
    dev_evt_code_i = 8'h5a;
    @(negedge clk_i);
    dev_evt_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("dev kind", rpb_pkg::RPB_NT_DEV, last_notif.kind);
    chk("dev code", 8'h5a, last_notif.code);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #160000;
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    end_of_test();
  end
  initial begin
    {srst_i, out_valid_i, cfg_wr_i, cfg_rd_i, rslt_taken_i} = 5'h10;
    {dev_evt_i, high_speed_i, hold, fail} = 4'h0;
    out_pkt_i = '0;
    cfg_pipe_i = 2'h0;
    cfg_desc_i = '0;
    port_status_i = 2'b00;
    dev_evt_code_i = 8'h00;
    repeat (4) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (6) @(posedge clk_i);
    t_config();
    t_out();
    t_err();
    t_in();
    t_speed();
    t_events();
    end_of_test();
  end
endmodule
